/* bench/therm_line_model.sv */
/* Open-drain thermal line with a pull-up, plus the host that may pull it.
   Assumes the host pull request comes from the bench. */
`timescale 1ns/1ps
`default_nettype none
module therm_line_model (
    input wire logic pin_o_i,
    input wire logic pin_oe_i,
    input wire logic host_pull_i,
    output logic level_b_o
);
    // A released line reads high from the pull-up, never the last value.
    assign level_b_o = ((pin_oe_i && !pin_o_i) || host_pull_i) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

/* bench/therm_pin_properties.sv */
/* Port checker for the thermal pin block.
   Assumes it is bound to the top module and sees one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module therm_pin_checker (
    input wire clk_i,
    input wire rst_b_i,
    input wire hsel_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire hready_i,
    input wire hreadyout_o,
    input wire hresp_o,
    input wire [31:0] hrdata_o,
    input wire meas_strobe_i,
    input wire therm_pin_o,
    input wire therm_pin_oe_o,
    input wire [7:0] tach_drive_map_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    wire rd_taken = hsel_i & hready_i & (htrans_i == 2'b10) & !hwrite_i;
    AST_RESP_OKAY: assert property (hresp_o == 1'b0)
        else $error("bus response not okay");
    AST_ZERO_WAIT: assert property ($past(rst_b_i) |-> hreadyout_o)
        else $error("slave inserted a wait state");
    AST_RDATA_HOLD: assert property (!$past(rd_taken) |-> $stable(hrdata_o))
        else $error("read data moved without a read");
    AST_RDATA_UPPER: assert property (hrdata_o[31:8] == 24'h0)
        else $error("read data upper bits set");
    AST_MAP_CODES: assert property (tach_drive_map_o inside {8'hf9, 8'ha9})
        else $error("tach map outside both modes");
    AST_PIN_LOW_ONLY: assert property (therm_pin_o == 1'b0)
        else $error("pin driven high");
    AST_TRIP_TIMING: assert property ($rose(therm_pin_oe_o) |->
        $past(meas_strobe_i, 2)) else $error("pin drive rose off strobe");
    AST_FREE_TIMING: assert property ($fell(therm_pin_oe_o) |->
        $past(meas_strobe_i, 2)) else $error("pin drive fell off strobe");
    AST_HOLD_CYCLE: assert property ($rose(therm_pin_oe_o) ##1
        !$past(meas_strobe_i, 2) |-> therm_pin_oe_o)
        else $error("pin released inside a monitoring cycle");
endmodule
////////////////////////////////////////////////////////////////////////////
bind therm_pin_protect_tach_sync therm_pin_checker chk (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .meas_strobe_i(meas_strobe_i), .therm_pin_o(therm_pin_o),
    .therm_pin_oe_o(therm_pin_oe_o), .tach_drive_map_o(tach_drive_map_o));
`default_nettype wire

/* bench/therm_pin_protect_tach_sync_bench.sv */
/* Self-checking bench for the thermal pin block.
   Assumes the line model and checker compile first. */
`timescale 1ns/1ps
`default_nettype none
`include "therm_consts.vh"
module therm_pin_protect_tach_sync_bench;
    localparam int TICK = 10;
    localparam logic [7:0] idx_tab [10] = '{`IDX_R1_CONFIG, `IDX_LOC_CONFIG,
        `IDX_R2_CONFIG, `IDX_ACOUSTIC_ONE, `IDX_R1_CRIT, `IDX_LOC_CRIT,
        `IDX_R2_CRIT, `IDX_MASK_TWO, `IDX_EVT_LIMIT, 8'h10};
    localparam logic [7:0] rst_tab [10] = '{8'h00, 8'h00, 8'h00, 8'h00,
        8'h64, 8'h64, 8'h64, 8'h00, 8'hff, 8'h00};
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic hsel_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [1:0] htrans_i = 2'b00;
    logic hwrite_i = 1'b0;
    logic [31:0] hwdata_i = 32'h0;
    logic meas_strobe_i = 1'b0;
    logic [9:0] temp [3] = '{10'h0, 10'h0, 10'h0};
    logic host_pull = 1'b0;
    wire hreadyout_o, hresp_o, therm_pin_o, therm_pin_oe_o, irq_o, pin_b;
    wire [31:0] hrdata_o;
    wire [7:0] tach_drive_map_o;
    int fails = 0;
    int n_checks = 0;
    logic [31:0] seed = 32'd40;
    logic [7:0] rd, lim;
    always #5 clk_i = ~clk_i;
    therm_pin_protect_tach_sync #(.EVT_TICK_CYCLES(TICK)) dut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
        .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
        .hsize_i(3'b010), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
        .meas_strobe_i(meas_strobe_i), .temp_remote1_i(temp[0]),
        .temp_local_i(temp[1]), .temp_remote2_i(temp[2]),
        .therm_pin_b_i(pin_b), .therm_pin_o(therm_pin_o),
        .therm_pin_oe_o(therm_pin_oe_o),
        .tach_drive_map_o(tach_drive_map_o), .irq_o(irq_o));
    therm_line_model line (.pin_o_i(therm_pin_o), .pin_oe_i(therm_pin_oe_o),
        .host_pull_i(host_pull), .level_b_o(pin_b));
////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] timer_exp(input int cyc);
        return (cyc / TICK < 2) ? 8'h01 : 8'(cyc / TICK);
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
        int k;
        hsel_i <= 1'b1;
        htrans_i <= `HTRANS_NONSEQ;
        haddr_i <= {22'h0, idx, 2'b00};
        hwrite_i <= wr;
        for (int p = 0; p < 2; p++) begin
            if (p == 1) begin
                hsel_i <= 1'b0;
                htrans_i <= 2'b00;
                hwdata_i <= {24'h0, wd};
            end
            k = 0;
            do begin
                @(posedge clk_i);
                k++;
            end while (hreadyout_o !== 1'b1 && k < 50);
            if (hreadyout_o !== 1'b1) fails++;
        end
        rd = hrdata_o[7:0];
    endtask
    task automatic rchk(input string what, input logic [7:0] idx,
                        input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check(what, {24'h0, rd}, {24'h0, exp});
    endtask
    task automatic strobe(input int c, input logic [9:0] own,
                          input logic [9:0] other, input logic exp);
        for (int k = 0; k < 3; k++) temp[k] <= (k == c) ? own : other;
        meas_strobe_i <= 1'b1;
        @(posedge clk_i);
        meas_strobe_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        check("pin drive", therm_pin_oe_o, exp);
    endtask
    task automatic pull(input int n);
        host_pull <= 1'b1;
        repeat (n) @(posedge clk_i);
        host_pull <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic clr();
        bus(1'b0, `IDX_EVT_TIMER, 8'h00);
        bus(1'b0, `IDX_STATUS_TWO, 8'h00);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        fails++;
        print_verdict();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        check("map", tach_drive_map_o, `MAP_DEFAULT);
        for (int i = 0; i < 10; i++) rchk("reset", idx_tab[i], rst_tab[i]);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            bus(1'b1, idx_tab[i], seed[7:0]);
            rchk("readback", idx_tab[i], seed[7:0]);
        end
        bus(1'b1, 8'h10, 8'h5a);
        rchk("unmapped", 8'h10, 8'h00);
        for (int s = 0; s < 2; s++) begin
            bus(1'b1, `IDX_ACOUSTIC_ONE, s ? 8'h10 : 8'h00);
            repeat (2) @(posedge clk_i);
            check("map", tach_drive_map_o, s ? `MAP_SYNC : `MAP_DEFAULT);
        end
        bus(1'b1, `IDX_MASK_TWO, 8'h00);
        for (int c = 0; c < 3; c++) begin
            seed = xs(seed);
            lim = {1'b0, seed[6:0]} + 8'h10;
            for (int j = 0; j < 3; j++)
                bus(1'b1, 8'(`IDX_R1_CONFIG + j), (j == c) ? 8'h08 : 8'h00);
            bus(1'b1, 8'(`IDX_R1_CRIT + c), lim);
            strobe(c, {lim, 2'b00}, 10'h3ff, 1'b0);
            strobe(c, {lim, 2'b01}, 10'h3ff, 1'b1);
            strobe(c, {lim, 2'b01}, 10'h000, 1'b1);
            strobe(c, {lim, 2'b00}, 10'h3ff, 1'b0);
        end
        for (int j = 0; j < 3; j++) bus(1'b1, 8'(`IDX_R1_CONFIG + j), 8'h08);
        strobe(0, 10'h3ff, 10'h3ff, 1'b1);
        strobe(0, 10'h000, 10'h3ff, 1'b1);
        strobe(0, 10'h000, 10'h000, 1'b0);
        check("irq", irq_o, 1'b1);
        rchk("status", `IDX_STATUS_TWO, 8'h02);
        clr();
        repeat (2) @(posedge clk_i);
        check("irq", irq_o, 1'b0);
        bus(1'b1, `IDX_EVT_LIMIT, 8'h00);
        bus(1'b1, `IDX_MASK_TWO, 8'h20);
        pull(3);
        check("irq", irq_o, 1'b0);
        rchk("status", `IDX_STATUS_TWO, 8'h20);
        clr();
        bus(1'b1, `IDX_MASK_TWO, 8'h00);
        pull(3);
        check("irq", irq_o, 1'b1);
        clr();
        bus(1'b1, `IDX_EVT_LIMIT, 8'h01);
        clr();
        pull(12);
        rchk("status", `IDX_STATUS_TWO, 8'h00);
        pull(33);
        rchk("status", `IDX_STATUS_TWO, 8'h20);
        rchk("timer", `IDX_EVT_TIMER, timer_exp(45));
        print_verdict();
    end
endmodule
`default_nettype wire

/* common/therm_consts.vh */
/*
 * Constants for the thermal-event pin, fan tach mapping and register block.
 * Assumes inclusion by bare name from design files under core/.
 */
`ifndef THERM_CONSTS_VH
`define THERM_CONSTS_VH

// Register indices; byte address is four times the index.
`define IDX_R1_CONFIG 8'h5f
`define IDX_LOC_CONFIG 8'h60
`define IDX_R2_CONFIG 8'h61
`define IDX_ACOUSTIC_ONE 8'h62
`define IDX_R1_CRIT 8'h6a
`define IDX_LOC_CRIT 8'h6b
`define IDX_R2_CRIT 8'h6c
`define IDX_MASK_TWO 8'h75
`define IDX_STATUS_TWO 8'h42
`define IDX_EVT_TIMER 8'h79
`define IDX_EVT_LIMIT 8'h7a

// Field positions.
`define BIT_OUT_EN 3
`define BIT_SYNC 4
`define BIT_THRESH 5
`define BIT_OVT 1

// Reset values.
`define RST_CONFIG 8'h00
`define RST_ACOUSTIC 8'h00
`define RST_CRIT 8'h64
`define RST_MASK 8'h00
`define RST_EVT_LIMIT 8'hff

// Tach-to-drive codes: 2'h1 drive one, 2'h2 drive two, 2'h3 drive three.
`define MAP_DEFAULT 8'hf9
`define MAP_SYNC 8'ha9

// Timing: clock period and timer resolution, both in ns.
`define CLK_PERIOD_NS 10
`define EVT_TICK_NS 22760000
`define EVT_BIG_UNITS 8'h02

// Bus encodings.
`define HTRANS_NONSEQ 2'b10

`endif

/* core/crit_trip.v */
/*
 * One temperature channel's critical trip: compares each new measurement
 * against its limit. Assumes meas_i pulses once per monitoring cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module crit_trip (
    input wire clk_i,
    input wire rst_b_i,
    input wire meas_i,
    input wire [9:0] temp_i,
    input wire [7:0] limit_i,
    input wire enable_i,
    output wire trip_o
);

reg trip_ff;

assign trip_o = trip_ff;

// Temperature carries two fraction bits, so one count above the scaled
// limit is a quarter degree over.  While enabled, the state only moves on a new
// sample, which keeps a trip for at least one whole monitoring cycle.
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        trip_ff <= 1'b0;
    end else if (!enable_i) begin
        trip_ff <= 1'b0;
    end else if (meas_i) begin
        trip_ff <= (temp_i > {limit_i, 2'b00});
    end
end

endmodule
`default_nettype wire

/* core/evt_timer.v */
/*
 * Cumulative thermal-event assertion timer with clear on read.
 * Assumes active_i is a synchronous level, high while the pin is asserted.
 */
`timescale 1ns/1ps
`default_nettype none
`include "therm_consts.vh"

module evt_timer #(
    parameter TICK_CYCLES = 2276000,
    parameter CNT_W = 22
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire active_i,
    input wire clear_i,
    output wire [7:0] value_o
);

localparam integer TICK_LAST_INT = TICK_CYCLES - 1;
localparam [CNT_W-1:0] TICK_LAST = TICK_LAST_INT[CNT_W-1:0];

reg [CNT_W-1:0] pre_ff;
reg [7:0] units_ff;
reg seen_ff;

// Below two units only the first-assertion bit shows.
assign value_o = (units_ff >= `EVT_BIG_UNITS) ? units_ff :
                 {7'h00, seen_ff};

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        pre_ff <= {CNT_W{1'b0}};
        units_ff <= 8'h00;
        seen_ff <= 1'b0;
    end else if (clear_i) begin
        pre_ff <= {CNT_W{1'b0}};
        units_ff <= 8'h00;
        seen_ff <= active_i;
    end else if (active_i) begin
        seen_ff <= 1'b1;
        if (pre_ff == TICK_LAST) begin
            pre_ff <= {CNT_W{1'b0}};
            if (units_ff != 8'hff) begin
                units_ff <= units_ff + 8'h01;
            end
        end else begin
            pre_ff <= pre_ff + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
end

endmodule
`default_nettype wire

/* core/therm_pin_protect_tach_sync.v */
/*
 * Thermal-event pin protection, event timer alerting and tach-to-drive
 * mapping behind an AHB-Lite register slave with zero wait states.
 * Assumes one AHB-Lite master, synchronous pin inputs and a measurement
 * strobe that pulses once per monitoring cycle with all three channels.
 */
`timescale 1ns/1ps
`default_nettype none
`include "therm_consts.vh"

////////////////////////////////////////////////////////////////////////////
module therm_pin_protect_tach_sync #(
    parameter EVT_TICK_CYCLES = `EVT_TICK_NS / `CLK_PERIOD_NS
) (
    input wire clk_i,
    input wire rst_b_i,
    input wire hsel_i,
    input wire [31:0] haddr_i,
    input wire [1:0] htrans_i,
    input wire hwrite_i,
    input wire [2:0] hsize_i,
    input wire [31:0] hwdata_i,
    input wire hready_i,
    output wire hreadyout_o,
    output wire hresp_o,
    output wire [31:0] hrdata_o,
    input wire meas_strobe_i,
    input wire [9:0] temp_remote1_i,
    input wire [9:0] temp_local_i,
    input wire [9:0] temp_remote2_i,
    input wire therm_pin_b_i,
    output wire therm_pin_o,
    output wire therm_pin_oe_o,
    output wire [7:0] tach_drive_map_o,
    output wire irq_o
);

////////////////////////////////////////////////////////////////////////////
// Storage

// Software-visible registers first; the writable ones take their reset values from the header.
reg [7:0] r1_config_ff;
reg [7:0] loc_config_ff;
reg [7:0] r2_config_ff;
reg [7:0] acoustic_one_ff;
reg [7:0] r1_crit_ff;
reg [7:0] loc_crit_ff;
reg [7:0] r2_crit_ff;
reg [7:0] mask_two_ff;
reg [7:0] status_two_ff;
reg [7:0] evt_limit_ff;
reg [31:0] hrdata_ff;
reg hreadyout_ff;
reg wr_pend_ff;
reg [7:0] wr_idx_ff;
reg pin_oe_ff;
reg [7:0] map_ff;
reg irq_ff;
reg hresp_ff;
reg pin_level_ff;

reg [7:0] nxt_status_two;
reg [7:0] rd_val;
reg [7:0] rd_word;

wire trip_r1;
wire trip_loc;
wire trip_r2;
wire [7:0] timer_val;
wire addr_take;
wire rd_take;
wire [7:0] rd_idx;
wire timer_clear;
wire status_clear;
wire evt_active;
wire any_trip;

////////////////////////////////////////////////////////////////////////////
// Helpers

// Word index from a byte address; both phases of the bus use it.
function [7:0] word_index;
    input [31:0] addr;
    begin
        word_index = addr[9:2];
    end
endfunction

function is_our_set;
    input [7:0] idx;
    input [7:0] target;
    begin
        is_our_set = (idx == target);
    end
endfunction

// Words that software may write; status and timer only change by hardware.
function writable;
    input [7:0] idx;
    begin
        case (idx)
            `IDX_R1_CONFIG, `IDX_LOC_CONFIG, `IDX_R2_CONFIG,
            `IDX_ACOUSTIC_ONE, `IDX_R1_CRIT, `IDX_LOC_CRIT,
            `IDX_R2_CRIT, `IDX_MASK_TWO, `IDX_EVT_LIMIT: writable = 1'b1;
            default: writable = 1'b0;
        endcase
    end
endfunction

// Two bits per tach input, tach one lowest, each naming the drive that
// the tach follows; tach one stays on drive one in both modes.
function [7:0] tach_map;
    input sync;
    begin
        if (sync) begin
            tach_map = `MAP_SYNC;
        end else begin
            tach_map = `MAP_DEFAULT;
        end
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// Bus slave

assign hreadyout_o = hreadyout_ff;
assign hresp_o = hresp_ff;
assign hrdata_o = hrdata_ff;

assign addr_take = hsel_i && hready_i && (htrans_i == `HTRANS_NONSEQ);
assign rd_take = addr_take && !hwrite_i;
assign rd_idx = word_index(haddr_i);

// Read side effects happen as the read is taken, so the returned data is
// the value before clearing.
assign timer_clear = rd_take && is_our_set(rd_idx, `IDX_EVT_TIMER);
assign status_clear = rd_take && is_our_set(rd_idx, `IDX_STATUS_TWO);

always @* begin
    case (rd_idx)
        `IDX_R1_CONFIG: rd_val = r1_config_ff;
        `IDX_LOC_CONFIG: rd_val = loc_config_ff;
        `IDX_R2_CONFIG: rd_val = r2_config_ff;
        `IDX_ACOUSTIC_ONE: rd_val = acoustic_one_ff;
        `IDX_R1_CRIT: rd_val = r1_crit_ff;
        `IDX_LOC_CRIT: rd_val = loc_crit_ff;
        `IDX_R2_CRIT: rd_val = r2_crit_ff;
        `IDX_MASK_TWO: rd_val = mask_two_ff;
        `IDX_STATUS_TWO: rd_val = status_two_ff;
        `IDX_EVT_TIMER: rd_val = timer_val;
        `IDX_EVT_LIMIT: rd_val = evt_limit_ff;
        default: rd_val = 8'h00;
    endcase
end

// A write is still in its data phase when the next address phase may read
// the same word, so that read returns the write data, not the stale value.
always @* begin
    if (wr_pend_ff && (wr_idx_ff == rd_idx)) begin
        rd_word = hwdata_i[7:0];
    end else begin
        rd_word = rd_val;
    end
end

// Ready stays low during reset, so no transfer can be taken before the
// registers have left reset.
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        hreadyout_ff <= 1'b0;
        hresp_ff <= 1'b0;
        hrdata_ff <= 32'h0000_0000;
        wr_pend_ff <= 1'b0;
        wr_idx_ff <= 8'h00;
    end else begin
        hreadyout_ff <= 1'b1;
        hresp_ff <= 1'b0;
        wr_pend_ff <= addr_take && hwrite_i && writable(rd_idx);
        if (addr_take) begin
            wr_idx_ff <= rd_idx;
        end
        if (rd_take) begin
            hrdata_ff <= {24'h00_0000, rd_word};
        end
    end
end

// Writes land in the data phase; status and timer are read-only.
// A write to an unmapped word is dropped without an error response.
always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        r1_config_ff <= `RST_CONFIG;
        loc_config_ff <= `RST_CONFIG;
        r2_config_ff <= `RST_CONFIG;
        acoustic_one_ff <= `RST_ACOUSTIC;
        r1_crit_ff <= `RST_CRIT;
        loc_crit_ff <= `RST_CRIT;
        r2_crit_ff <= `RST_CRIT;
        mask_two_ff <= `RST_MASK;
        evt_limit_ff <= `RST_EVT_LIMIT;
    end else if (wr_pend_ff) begin
        case (wr_idx_ff)
            `IDX_R1_CONFIG: r1_config_ff <= hwdata_i[7:0];
            `IDX_LOC_CONFIG: loc_config_ff <= hwdata_i[7:0];
            `IDX_R2_CONFIG: r2_config_ff <= hwdata_i[7:0];
            `IDX_ACOUSTIC_ONE: acoustic_one_ff <= hwdata_i[7:0];
            `IDX_R1_CRIT: r1_crit_ff <= hwdata_i[7:0];
            `IDX_LOC_CRIT: loc_crit_ff <= hwdata_i[7:0];
            `IDX_R2_CRIT: r2_crit_ff <= hwdata_i[7:0];
            `IDX_MASK_TWO: mask_two_ff <= hwdata_i[7:0];
            `IDX_EVT_LIMIT: evt_limit_ff <= hwdata_i[7:0];
            default: evt_limit_ff <= evt_limit_ff;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////
// Pin as an output

// One comparator per channel, each against its own limit register.
crit_trip u_trip_r1 (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .meas_i(meas_strobe_i),
    .temp_i(temp_remote1_i),
    .limit_i(r1_crit_ff),
    .enable_i(r1_config_ff[`BIT_OUT_EN]),
    .trip_o(trip_r1)
);

crit_trip u_trip_loc (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .meas_i(meas_strobe_i),
    .temp_i(temp_local_i),
    .limit_i(loc_crit_ff),
    .enable_i(loc_config_ff[`BIT_OUT_EN]),
    .trip_o(trip_loc)
);

crit_trip u_trip_r2 (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .meas_i(meas_strobe_i),
    .temp_i(temp_remote2_i),
    .limit_i(r2_crit_ff),
    .enable_i(r2_config_ff[`BIT_OUT_EN]),
    .trip_o(trip_r2)
);

assign any_trip = trip_r1 | trip_loc | trip_r2;

// Open drain: the driven level is always low, only the enable moves.
assign therm_pin_o = pin_level_ff;
assign therm_pin_oe_o = pin_oe_ff;

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        pin_oe_ff <= 1'b0;
        pin_level_ff <= 1'b0;
    end else begin
        pin_oe_ff <= any_trip;
        pin_level_ff <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////
// Pin as an input

// Our own drive would look like an external event, so it is not counted.
assign evt_active = !therm_pin_b_i && !pin_oe_ff;

// The wide prescaler covers any tick length the parameter may be given;
// a shorter tick only shortens the wait, not the timer's behaviour.
evt_timer #(
    .TICK_CYCLES(EVT_TICK_CYCLES),
    .CNT_W(32)
) u_evt_timer (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .active_i(evt_active),
    .clear_i(timer_clear),
    .value_o(timer_val)
);

////////////////////////////////////////////////////////////////////////////
// Status and interrupt

// A set in the same cycle as a clearing read wins over the clear.
// The overtemperature bit is sticky too, so software still sees a trip
// after the pin has been freed.
always @* begin
    nxt_status_two = status_clear ? 8'h00 : status_two_ff;
    if (timer_val > evt_limit_ff) begin
        nxt_status_two[`BIT_THRESH] = 1'b1;
    end
    if (any_trip) begin
        nxt_status_two[`BIT_OVT] = 1'b1;
    end
end

// The interrupt follows the next status value, so it rises together with
// the status bit that it reports.
assign irq_o = irq_ff;

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        status_two_ff <= 8'h00;
        irq_ff <= 1'b0;
    end else begin
        status_two_ff <= nxt_status_two;
        irq_ff <= |(nxt_status_two & ~mask_two_ff);
    end
end

////////////////////////////////////////////////////////////////////////////
// Tach synchronisation map

assign tach_drive_map_o = map_ff;

always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
        map_ff <= `MAP_DEFAULT;
    end else begin
        map_ff <= tach_map(acoustic_one_ff[`BIT_SYNC]);
    end
end

endmodule
`default_nettype wire
